// File: uop_tag_regs.svh
/*
 * Register offsets, field positions and reset values of the micro-op
 * tagging block. Assumes inclusion by the design file and the bench.
 */
`ifndef UOP_TAG_REGS_SVH
`define UOP_TAG_REGS_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define OFS_TAG_ENABLE      8'h00
`define OFS_TAG_MATRIX      8'h04
`define OFS_LOAD_PORT_SEL   8'h08
`define OFS_STORE_PORT_SEL  8'h0c
`define OFS_EXEC_SEL        8'h10
`define OFS_UOP_TYPE_SEL    8'h14
`define OFS_CNT_REPLAY      8'h18
`define OFS_CNT_FRONT       8'h1c
`define OFS_CNT_EXEC        8'h20

// ****************************************************************
// Tag enable register bits
// ****************************************************************
`define EN_L1_MISS     0
`define EN_L2_MISS     1
`define EN_TLB_MISS    2
`define EN_ORDER       9
`define EN_SPLIT       10
`define EN_BR_A        15
`define EN_BR_B        16
`define EN_GATE_A      24
`define EN_GATE_B      25

// ****************************************************************
// Matrix register and event-select bits
// ****************************************************************
`define MX_LOAD        0
`define MX_STORE       1
`define MX_BRANCH      4
`define SEL_EVENT_ON   0
`define SEL_PARTIAL    1
`define SEL_UNALIGNED  2
`define SEL_SPLIT      3
`define UT_LOADS       0
`define UT_STORES      1
`define EX_ALL         0
`define EX_MARK_EN     1
`define EX_VALUE_LSB   2
`define EX_CLASS_LSB   4
`define EX_MARK_VALUE  2'h1
`define RST_WORD       32'h0000_0000

`endif

// File: uop_tag_pkg.sv
/*
 * Types of the micro-op tagging block.
 * Assumes the register header is compiled alongside.
 */
package uop_tag_pkg;

   // Micro-op class as seen at dispatch
   typedef enum logic [2:0] {
      UC_OTHER  = 3'b000,
      UC_LOAD   = 3'b001,
      UC_STORE  = 3'b010,
      UC_BRANCH = 3'b011,
      UC_PSP    = 3'b100,
      UC_SSP    = 3'b101,
      UC_SDP    = 3'b110,
      UC_X87    = 3'b111
   } uop_class_t;

   // Dispatch-side description of one micro-op
   typedef struct packed {
      logic       valid;
      logic [4:0] idx;
      uop_class_t cls;
      logic       io_or_uc;
      logic       locked;
      logic       ret_or_far;
      logic       l1_miss;
      logic       l2_miss;
      logic       tlb_miss;
      logic       ord_replay;
      logic       split;
      logic       mispred;
      logic       fp_stack_fault;
   } uop_info_t;

   // Retire/discard port
   typedef struct packed {
      logic       retire;
      logic       discard;
      logic [4:0] idx;
   } uop_done_t;

   typedef struct packed {
      logic [31:0] enable;
      logic [31:0] matrix;
      logic [31:0] ld_sel;
      logic [31:0] st_sel;
      logic [31:0] ex_sel;
      logic [31:0] ut_sel;
      logic [31:0] cnt_rep;
      logic [31:0] cnt_fe;
      logic [31:0] cnt_ex;
      logic [31:0] tag_rep;
      logic [31:0] tag_fe;
      logic [31:0] tag_ex;
      logic        dphase;
      logic        dwrite;
      logic [7:0]  daddr;
      logic [31:0] rdata;
   } state_t;

endpackage

// File: uop_tagging_retire_counter.sv
/*
 * Micro-op tagging and at-retirement counting with an AHB-Lite slave.
 * Assumes a core pipeline on clk_sys gives one dispatch and one
 * retire/discard per cycle, indexed into a 32-entry window.
 */
`timescale 1ns/1ps
`include "uop_tag_regs.svh"

module uop_tagging_retire_counter (
   input  wire logic                   clk_sys,
   input  wire logic                   rst,
   input  wire logic                   hsel,
   input  wire logic [31:0]            haddr,
   input  wire logic [1:0]             htrans,
   input  wire logic                   hwrite,
   input  wire logic [2:0]             hsize,
   input  wire logic [31:0]            hwdata,
   input  wire logic                   hready,
   output logic      [31:0]            hrdata,
   output logic                        hreadyout,
   output logic                        hresp,
   input  wire uop_tag_pkg::uop_info_t dispatch,
   input  wire uop_tag_pkg::uop_done_t done,
   output logic                        replay_tagged,
   output logic                        front_tagged,
   output logic                        exec_tagged
);

   uop_tag_pkg::state_t st_ff;
   uop_tag_pkg::state_t nxt_st;

   // Replay tag decision for one dispatched micro-op
   function automatic logic replay_mark(input uop_tag_pkg::state_t s,
                                        input uop_tag_pkg::uop_info_t u);
      logic gate;
      logic ld;
      logic sto;
      logic hit;
      gate = s.enable[`EN_GATE_A] & s.enable[`EN_GATE_B];
      ld   = (u.cls == uop_tag_pkg::UC_LOAD)  & s.matrix[`MX_LOAD];
      sto  = (u.cls == uop_tag_pkg::UC_STORE) & s.matrix[`MX_STORE];
      hit  = 1'b0;
      if ((s.enable[`EN_L1_MISS] & u.l1_miss) | (s.enable[`EN_L2_MISS] & u.l2_miss)) begin
         hit = hit | ld;
      end
      if (s.enable[`EN_TLB_MISS] & u.tlb_miss) begin
         hit = hit | ld | sto;
      end
      if (s.enable[`EN_BR_A] & s.enable[`EN_BR_B] & s.matrix[`MX_BRANCH]
          & (u.cls == uop_tag_pkg::UC_BRANCH) & u.mispred) begin
         hit = 1'b1;
      end
      if (s.enable[`EN_ORDER] & u.ord_replay & ld & s.ld_sel[`SEL_EVENT_ON]
          & s.ld_sel[`SEL_PARTIAL] & s.ld_sel[`SEL_UNALIGNED]) begin
         hit = 1'b1;
      end
      if (s.enable[`EN_SPLIT] & u.split) begin
         hit = hit | (ld & s.ld_sel[`SEL_EVENT_ON] & s.ld_sel[`SEL_SPLIT])
                   | (sto & s.st_sel[`SEL_EVENT_ON] & s.st_sel[`SEL_SPLIT]);
      end
      // Excluded kinds of access never carry a replay tag
      replay_mark = gate & hit & ~u.io_or_uc & ~u.locked & ~u.ret_or_far;
   endfunction

   // Execution class match against the upstream selection
   function automatic logic exec_mark(input uop_tag_pkg::state_t s,
                                      input uop_tag_pkg::uop_info_t u);
      exec_mark = s.ex_sel[`EX_ALL] & s.ex_sel[`EX_MARK_EN]
                  & (s.ex_sel[`EX_VALUE_LSB +: 2] == `EX_MARK_VALUE)
                  & (u.cls == uop_tag_pkg::uop_class_t'(s.ex_sel[`EX_CLASS_LSB +: 3]));
   endfunction

   // Register read mux
   function automatic logic [31:0] reg_read(input uop_tag_pkg::state_t s,
                                            input logic [7:0] a);
      case (a)
         `OFS_TAG_ENABLE:     reg_read = s.enable;
         `OFS_TAG_MATRIX:     reg_read = s.matrix;
         `OFS_LOAD_PORT_SEL:  reg_read = s.ld_sel;
         `OFS_STORE_PORT_SEL: reg_read = s.st_sel;
         `OFS_EXEC_SEL:       reg_read = s.ex_sel;
         `OFS_UOP_TYPE_SEL:   reg_read = s.ut_sel;
         `OFS_CNT_REPLAY:     reg_read = s.cnt_rep;
         `OFS_CNT_FRONT:      reg_read = s.cnt_fe;
         `OFS_CNT_EXEC:       reg_read = s.cnt_ex;
         default:             reg_read = 32'h0000_0000;
      endcase
   endfunction

   logic ret_rep;
   logic ret_fe;
   logic ret_ex;

   // Tag lookups at retirement; discards never count
   always_comb begin
      ret_rep = done.retire & st_ff.tag_rep[done.idx];
      ret_fe  = done.retire & st_ff.tag_fe[done.idx];
      ret_ex  = done.retire & st_ff.tag_ex[done.idx];
   end

   // Next state: bus slave, tag window and counters
   always_comb begin
      logic        fe;
      logic        wr;
      fe = 1'b0;
      wr = st_ff.dphase & st_ff.dwrite;
      nxt_st = st_ff;
      nxt_st.dphase = hsel & htrans[1] & hready;
      if (hsel & htrans[1] & hready) begin
         nxt_st.dwrite = hwrite;
         nxt_st.daddr  = haddr[7:0];
      end
      if (wr) begin
         case (st_ff.daddr)
            `OFS_TAG_ENABLE:     nxt_st.enable = hwdata;
            `OFS_TAG_MATRIX:     nxt_st.matrix = hwdata;
            `OFS_LOAD_PORT_SEL:  nxt_st.ld_sel = hwdata;
            `OFS_STORE_PORT_SEL: nxt_st.st_sel = hwdata;
            `OFS_EXEC_SEL:       nxt_st.ex_sel = hwdata;
            `OFS_UOP_TYPE_SEL:   nxt_st.ut_sel = hwdata;
            `OFS_CNT_REPLAY:     nxt_st.cnt_rep = hwdata;
            `OFS_CNT_FRONT:      nxt_st.cnt_fe = hwdata;
            `OFS_CNT_EXEC:       nxt_st.cnt_ex = hwdata;
            default:             nxt_st.enable = st_ff.enable;
         endcase
      end
      // Read after the landing write, so a back-to-back read sees the new word
      if (hsel & htrans[1] & hready) begin
         nxt_st.rdata = reg_read(nxt_st, haddr[7:0]);
      end
      // Clear first, so a same-index dispatch in this cycle wins
      if (done.retire | done.discard) begin
         nxt_st.tag_rep[done.idx] = 1'b0;
         nxt_st.tag_fe[done.idx]  = 1'b0;
         nxt_st.tag_ex[done.idx]  = 1'b0;
      end
      if (dispatch.valid) begin
         // Loads and stores marked for the front-end count
         fe = ((dispatch.cls == uop_tag_pkg::UC_LOAD) & st_ff.ut_sel[`UT_LOADS])
            | ((dispatch.cls == uop_tag_pkg::UC_STORE) & st_ff.ut_sel[`UT_STORES]);
         // An FP stack fault drops the mark: tolerated undercount
         fe = fe & ~dispatch.fp_stack_fault & ~dispatch.io_or_uc & ~dispatch.locked;
         nxt_st.tag_rep[dispatch.idx] = replay_mark(st_ff, dispatch);
         nxt_st.tag_fe[dispatch.idx]  = fe;
         nxt_st.tag_ex[dispatch.idx]  = exec_mark(st_ff, dispatch);
      end
      // Counters advance only on tagged non-speculative retirements
      if (ret_rep & ~(wr & (st_ff.daddr == `OFS_CNT_REPLAY))) begin
         nxt_st.cnt_rep = st_ff.cnt_rep + 32'h0000_0001;
      end
      if (ret_fe & ~(wr & (st_ff.daddr == `OFS_CNT_FRONT))) begin
         nxt_st.cnt_fe = st_ff.cnt_fe + 32'h0000_0001;
      end
      if (ret_ex & ~(wr & (st_ff.daddr == `OFS_CNT_EXEC))) begin
         nxt_st.cnt_ex = st_ff.cnt_ex + 32'h0000_0001;
      end
   end

   // Single state register
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // Zero-wait slave, always OKAY
   always_comb begin
      hrdata        = st_ff.rdata;
      hreadyout     = 1'b1;
      hresp         = 1'b0;
      replay_tagged = ret_rep;
      front_tagged  = ret_fe;
      exec_tagged   = ret_ex;
   end

   // ****************************************************************
   // Checks
   // ****************************************************************
   property p_untagged_no_count;
      @(posedge clk_sys) disable iff (rst)
      (done.retire & ~st_ff.tag_rep[done.idx] & ~st_ff.dphase)
         |=> (st_ff.cnt_rep == $past(st_ff.cnt_rep));
   endproperty
   a_untagged_no_count: assert property (p_untagged_no_count)
      else $error("untagged retire changed replay count");

   property p_excluded_untagged;
      @(posedge clk_sys) disable iff (rst)
      (dispatch.valid & dispatch.locked & ~(done.retire & done.idx == dispatch.idx))
         |=> ~st_ff.tag_rep[$past(dispatch.idx)];
   endproperty
   a_excluded_untagged: assert property (p_excluded_untagged)
      else $error("locked op got a replay tag");

   property p_gate_needed;
      @(posedge clk_sys) disable iff (rst)
      (dispatch.valid & ~st_ff.enable[`EN_GATE_A])
         |=> ~st_ff.tag_rep[$past(dispatch.idx)];
   endproperty
   a_gate_needed: assert property (p_gate_needed)
      else $error("replay tag without gate bits");

   property p_exec_count;
      @(posedge clk_sys) disable iff (rst)
      (ret_ex & ~st_ff.dphase) |=> (st_ff.cnt_ex == $past(st_ff.cnt_ex) + 32'h1);
   endproperty
   a_exec_count: assert property (p_exec_count)
      else $error("exec count missed a tagged retire");

   property p_split_needs_event;
      @(posedge clk_sys) disable iff (rst)
      (dispatch.valid & dispatch.split & ~dispatch.tlb_miss & ~dispatch.l1_miss
       & ~dispatch.l2_miss & ~dispatch.ord_replay & ~dispatch.mispred
       & ~st_ff.ld_sel[`SEL_EVENT_ON] & (dispatch.cls == uop_tag_pkg::UC_LOAD))
         |=> ~st_ff.tag_rep[$past(dispatch.idx)];
   endproperty
   a_split_needs_event: assert property (p_split_needs_event)
      else $error("split load tagged without port event");

   property p_discard_clears;
      @(posedge clk_sys) disable iff (rst)
      (done.discard & ~(dispatch.valid & dispatch.idx == done.idx))
         |=> ~st_ff.tag_ex[$past(done.idx)];
   endproperty
   a_discard_clears: assert property (p_discard_clears)
      else $error("discard left a tag");

   property p_front_load;
      @(posedge clk_sys) disable iff (rst)
      (dispatch.valid & (dispatch.cls == uop_tag_pkg::UC_LOAD) & st_ff.ut_sel[`UT_LOADS]
       & ~dispatch.fp_stack_fault & ~dispatch.io_or_uc & ~dispatch.locked)
         |=> st_ff.tag_fe[$past(dispatch.idx)];
   endproperty
   a_front_load: assert property (p_front_load)
      else $error("load not marked for front-end count");

   property p_exec_value;
      @(posedge clk_sys) disable iff (rst)
      (dispatch.valid & (st_ff.ex_sel[`EX_VALUE_LSB +: 2] != `EX_MARK_VALUE))
         |=> ~st_ff.tag_ex[$past(dispatch.idx)];
   endproperty
   a_exec_value: assert property (p_exec_value)
      else $error("exec tag with wrong mark value");

   property p_io_untagged;
      @(posedge clk_sys) disable iff (rst)
      (dispatch.valid & (dispatch.io_or_uc | dispatch.ret_or_far))
         |=> ~st_ff.tag_rep[$past(dispatch.idx)];
   endproperty
   a_io_untagged: assert property (p_io_untagged)
      else $error("excluded op got a replay tag");

   property p_branch_needs_bits;
      @(posedge clk_sys) disable iff (rst)
      (dispatch.valid & (dispatch.cls == uop_tag_pkg::UC_BRANCH) & ~st_ff.enable[`EN_BR_B])
         |=> ~st_ff.tag_rep[$past(dispatch.idx)];
   endproperty
   a_branch_needs_bits: assert property (p_branch_needs_bits)
      else $error("branch tagged without branch enables");

   property p_order_needs_qual;
      @(posedge clk_sys) disable iff (rst)
      (dispatch.valid & dispatch.ord_replay & ~dispatch.l1_miss & ~dispatch.l2_miss
       & ~dispatch.tlb_miss & ~dispatch.split & ~dispatch.mispred
       & ~st_ff.ld_sel[`SEL_UNALIGNED])
         |=> ~st_ff.tag_rep[$past(dispatch.idx)];
   endproperty
   a_order_needs_qual: assert property (p_order_needs_qual)
      else $error("ordering replay tagged without qualifiers");

   property p_fault_no_front;
      @(posedge clk_sys) disable iff (rst)
      (dispatch.valid & dispatch.fp_stack_fault)
         |=> ~st_ff.tag_fe[$past(dispatch.idx)];
   endproperty
   a_fault_no_front: assert property (p_fault_no_front)
      else $error("front mark kept on stack fault");

   property p_front_store;
      @(posedge clk_sys) disable iff (rst)
      (dispatch.valid & (dispatch.cls == uop_tag_pkg::UC_STORE) & st_ff.ut_sel[`UT_STORES]
       & ~dispatch.fp_stack_fault & ~dispatch.io_or_uc & ~dispatch.locked)
         |=> st_ff.tag_fe[$past(dispatch.idx)];
   endproperty
   a_front_store: assert property (p_front_store)
      else $error("store not marked for front-end count");

   property p_front_count;
      @(posedge clk_sys) disable iff (rst)
      (ret_fe & ~st_ff.dphase) |=> (st_ff.cnt_fe == $past(st_ff.cnt_fe) + 32'h1);
   endproperty
   a_front_count: assert property (p_front_count)
      else $error("front count missed a tagged retire");

   property p_replay_count;
      @(posedge clk_sys) disable iff (rst)
      (ret_rep & ~st_ff.dphase) |=> (st_ff.cnt_rep == $past(st_ff.cnt_rep) + 32'h1);
   endproperty
   a_replay_count: assert property (p_replay_count)
      else $error("replay count missed a tagged retire");

   property p_exec_untagged;
      @(posedge clk_sys) disable iff (rst)
      (done.retire & ~st_ff.tag_ex[done.idx] & ~st_ff.dphase)
         |=> (st_ff.cnt_ex == $past(st_ff.cnt_ex));
   endproperty
   a_exec_untagged: assert property (p_exec_untagged)
      else $error("untagged retire changed exec count");

endmodule

// File: uop_tagging_retire_counter_tb.sv
/*
 * Self-checking bench of the micro-op tagging block: registers over an
 * AHB-Lite master, micro-ops dispatched and retired from the bench.
 * Assumes the package and the register header compiled alongside.
 */
`timescale 1ns/1ps
`include "uop_tag_regs.svh"

module uop_tagging_retire_counter_tb;

   // ************************************************************
   // Signals
   // ************************************************************
   localparam logic [31:0] G    = 32'h0300_0000;
   localparam logic [9:0]  F_IO = 10'h200, F_LK = 10'h100, F_RF = 10'h080;
   localparam logic [9:0]  F_L1 = 10'h040, F_L2 = 10'h020, F_TLB = 10'h010;
   localparam logic [9:0]  F_ORD = 10'h008, F_SPL = 10'h004, F_MIS = 10'h002;
   localparam logic [9:0]  F_FP = 10'h001;
   logic                   clk_sys, rst, hsel, hwrite, hreadyout, hresp;
   logic [31:0]            haddr, hwdata, hrdata, rd;
   logic [1:0]             htrans;
   logic [2:0]             hsize;
   uop_tag_pkg::uop_info_t dispatch;
   uop_tag_pkg::uop_done_t done;
   logic                   replay_tagged, front_tagged, exec_tagged;
   logic [4:0]             slot;
   int                     n_fail, cmp_count, exp_rep, exp_fe, exp_ex;

   uop_tagging_retire_counter uut (
      .clk_sys(clk_sys), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .dispatch(dispatch),
      .done(done), .replay_tagged(replay_tagged), .front_tagged(front_tagged),
      .exec_tagged(exec_tagged));

   // Free-running 200 MHz clock
   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end

   // ************************************************************
   // Compare and report
   // ************************************************************
   task automatic chk32(input string what, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic chk1(input string what, input logic exp, input logic got);
      cmp_count++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value %s expected %b seen %b", what, exp, got);
      end
   endtask

   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // ************************************************************
   // Bus master and pipeline drivers
   // ************************************************************
   // Holds each phase until hready is seen high; only the watchdog ends a wait
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] q);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= wr;
      hsize <= 3'h2;
      do @(posedge clk_sys); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= wd;
      do @(posedge clk_sys); while (hreadyout !== 1'b1);
      q = hrdata;
      chk1("okay response", 1'b0, hresp);
   endtask

   task automatic cfg(input logic [31:0] en, mx, ld, st, ut, ex);
      bus(1'b1, `OFS_TAG_ENABLE, en, rd);
      bus(1'b1, `OFS_TAG_MATRIX, mx, rd);
      bus(1'b1, `OFS_LOAD_PORT_SEL, ld, rd);
      bus(1'b1, `OFS_STORE_PORT_SEL, st, rd);
      bus(1'b1, `OFS_UOP_TYPE_SEL, ut, rd);
      bus(1'b1, `OFS_EXEC_SEL, ex, rd);
   endtask

   task automatic put(input uop_tag_pkg::uop_class_t c, input logic [9:0] f);
      dispatch <= {1'b1, slot, c, f};
      @(posedge clk_sys);
      dispatch <= '0;
   endtask

   // Pulses are combinational, so they are looked at mid-cycle
   task automatic take(input logic disc, input logic r, input logic fe, input logic ex);
      done <= {~disc, disc, slot};
      @(negedge clk_sys);
      chk1("replay pulse", r, replay_tagged);
      chk1("front pulse", fe, front_tagged);
      chk1("exec pulse", ex, exec_tagged);
      @(posedge clk_sys);
      done <= '0;
      @(posedge clk_sys);
      exp_rep += r;
      exp_fe += fe;
      exp_ex += ex;
      if (!disc)
         slot++;
   endtask

   // Watchdog: the whole sequence needs well under 5000 cycles
   initial begin
      repeat (20000) @(posedge clk_sys);
      n_fail++;
      print_verdict();
   end

   // ************************************************************
   // Test sequence
   // ************************************************************
   initial begin
      logic [7:0] offs [9];
      offs = '{`OFS_TAG_ENABLE, `OFS_TAG_MATRIX, `OFS_LOAD_PORT_SEL, `OFS_STORE_PORT_SEL,
               `OFS_EXEC_SEL, `OFS_UOP_TYPE_SEL, `OFS_CNT_REPLAY, `OFS_CNT_FRONT,
               `OFS_CNT_EXEC};
      rst = 1'b1; hsel = 1'b0; haddr = '0; htrans = 2'h0; hwrite = 1'b0;
      hsize = 3'h2; hwdata = '0; dispatch = '0; done = '0; slot = 5'h00;
      n_fail = 0; cmp_count = 0; exp_rep = 0; exp_fe = 0; exp_ex = 0;
      repeat (10) @(posedge clk_sys);
      rst <= 1'b0;
      @(posedge clk_sys);
      // Reset values, unmapped place, read-back
      foreach (offs[i]) begin
         bus(1'b0, offs[i], '0, rd);
         chk32("reset value", `RST_WORD, rd);
      end
      bus(1'b1, 8'h24, 32'hffff_ffff, rd);
      bus(1'b0, 8'h24, '0, rd);
      chk32("unmapped", 32'h0, rd);
      bus(1'b1, `OFS_TAG_MATRIX, 32'h0000_0013, rd);
      bus(1'b0, `OFS_TAG_MATRIX, '0, rd);
      chk32("matrix", 32'h0000_0013, rd);
      $display("test registers done");
      // Replay tags, excluded kinds and missing enables
      cfg(G | 32'h1, 32'h1, 0, 0, 0, 0);
      put(uop_tag_pkg::UC_LOAD, F_L1); take(0, 1, 0, 0);
      put(uop_tag_pkg::UC_LOAD, F_L1 | F_IO); take(0, 0, 0, 0);
      put(uop_tag_pkg::UC_LOAD, F_L1 | F_LK); take(0, 0, 0, 0);
      put(uop_tag_pkg::UC_LOAD, F_L1 | F_RF); take(0, 0, 0, 0);
      put(uop_tag_pkg::UC_LOAD, F_L1); take(1, 0, 0, 0);
      take(0, 0, 0, 0);
      put(uop_tag_pkg::UC_LOAD, 10'h0); take(0, 0, 0, 0);
      cfg(32'h0100_0001, 32'h1, 0, 0, 0, 0);
      put(uop_tag_pkg::UC_LOAD, F_L1); take(0, 0, 0, 0);
      cfg(G | 32'h1, 32'h0, 0, 0, 0, 0);
      put(uop_tag_pkg::UC_LOAD, F_L1); take(0, 0, 0, 0);
      cfg(G | 32'h2, 32'h1, 0, 0, 0, 0);
      put(uop_tag_pkg::UC_LOAD, F_L2); take(0, 1, 0, 0);
      put(uop_tag_pkg::UC_LOAD, F_L1); take(0, 0, 0, 0);
      cfg(G | 32'h4, 32'h2, 0, 0, 0, 0);
      put(uop_tag_pkg::UC_STORE, F_TLB); take(0, 1, 0, 0);
      put(uop_tag_pkg::UC_LOAD, F_TLB); take(0, 0, 0, 0);
      cfg(G | 32'h4, 32'h3, 0, 0, 0, 0);
      put(uop_tag_pkg::UC_LOAD, F_TLB); take(0, 1, 0, 0);
      cfg(G | 32'h1_8000, 32'h10, 0, 0, 0, 0);
      put(uop_tag_pkg::UC_BRANCH, F_MIS); take(0, 1, 0, 0);
      cfg(G | 32'h8000, 32'h10, 0, 0, 0, 0);
      put(uop_tag_pkg::UC_BRANCH, F_MIS); take(0, 0, 0, 0);
      cfg(G | 32'h200, 32'h1, 32'h7, 32'h7, 0, 0);
      put(uop_tag_pkg::UC_LOAD, F_ORD); take(0, 1, 0, 0);
      cfg(G | 32'h200, 32'h1, 32'h3, 32'h3, 0, 0);
      put(uop_tag_pkg::UC_LOAD, F_ORD); take(0, 0, 0, 0);
      cfg(G | 32'h400, 32'h1, 32'h9, 0, 0, 0);
      put(uop_tag_pkg::UC_LOAD, F_SPL); take(0, 1, 0, 0);
      cfg(G | 32'h400, 32'h1, 32'h1, 0, 0, 0);
      put(uop_tag_pkg::UC_LOAD, F_SPL); take(0, 0, 0, 0);
      cfg(G | 32'h400, 32'h2, 0, 32'h9, 0, 0);
      put(uop_tag_pkg::UC_STORE, F_SPL); take(0, 1, 0, 0);
      put(uop_tag_pkg::UC_LOAD, F_SPL); take(0, 0, 0, 0);
      bus(1'b0, `OFS_CNT_REPLAY, '0, rd);
      chk32("replay count", 32'(exp_rep), rd);
      $display("test replay done");
      // Front-end marking of loads and stores
      cfg(0, 0, 0, 0, 32'h1, 0);
      put(uop_tag_pkg::UC_LOAD, 10'h0); take(0, 0, 1, 0);
      put(uop_tag_pkg::UC_STORE, 10'h0); take(0, 0, 0, 0);
      put(uop_tag_pkg::UC_LOAD, F_FP); take(0, 0, 0, 0);
      put(uop_tag_pkg::UC_LOAD, F_IO); take(0, 0, 0, 0);
      cfg(0, 0, 0, 0, 32'h2, 0);
      put(uop_tag_pkg::UC_STORE, 10'h0); take(0, 0, 1, 0);
      put(uop_tag_pkg::UC_STORE, 10'h0); take(1, 0, 0, 0);
      bus(1'b0, `OFS_CNT_FRONT, '0, rd);
      chk32("front count", 32'(exp_fe), rd);
      $display("test front-end done");
      // Execution marking for classes UC_PSP to UC_X87
      for (int k = 4; k < 8; k++) begin
         cfg(0, 0, 0, 0, 0, {25'h0, k[2:0], 4'h7});
         put(uop_tag_pkg::uop_class_t'(k[2:0]), 10'h0); take(0, 0, 0, 1);
      end
      cfg(0, 0, 0, 0, 0, 32'h0000_007b);
      put(uop_tag_pkg::UC_X87, 10'h0); take(0, 0, 0, 0);
      cfg(0, 0, 0, 0, 0, 32'h0000_0075);
      put(uop_tag_pkg::UC_X87, 10'h0); take(0, 0, 0, 0);
      cfg(0, 0, 0, 0, 0, 32'h0000_0077);
      put(uop_tag_pkg::UC_LOAD, 10'h0); take(0, 0, 0, 0);
      put(uop_tag_pkg::UC_X87, 10'h0); take(1, 0, 0, 0);
      bus(1'b0, `OFS_CNT_EXEC, '0, rd);
      chk32("exec count", 32'(exp_ex), rd);
      $display("test execution done");
      print_verdict();
   end

endmodule
